// File: prbs_chk_map.svh
`ifndef PRBS_CHK_MAP_SVH
`define PRBS_CHK_MAP_SVH

// register indices; byte address is four times the index
`define SCK_CTRL_IDX     8'h39
`define SCK_TOTAL_IDX    8'h3A
`define SCK_IRQ_STS_IDX  8'h3B
`define SCK_IRQ_CLR_IDX  8'h3C
`define SCK_IRQ_EN_IDX   8'h3D

// control/status field positions
`define SCK_ON_BIT       0
`define SCK_CONT_BIT     1
`define SCK_OVF_BIT      2
`define SCK_LOCK_BIT     4
`define SCK_SLOSS_BIT    5
`define SCK_ERR_LSB      7
`define SCK_ERR_MSB      14
`define SCK_FREEZE_BIT   7
`define SCK_FRZCLR_BIT   8

// interrupt status/clear/enable bit positions
`define SCK_IRQ_LOSS     0
`define SCK_IRQ_OVF      1
`define SCK_IRQ_LOCK     2

// reset values
`define SCK_CTRL_RST     16'h0000
`define SCK_TOTAL_RST    16'h0000

// lock qualification counts, in bytes
`define SCK_LOCK_GOOD    8
`define SCK_LOSS_BAD     4

`endif

// File: prbs_chk_pkg.sv
package prbs_chk_pkg;
    typedef enum {ST_HUNT, ST_LOCKED} lock_state_type;
    typedef logic [31:0] bus_word_type;
    typedef logic [11:0] bus_addr_type;
endpackage : prbs_chk_pkg

// File: seq_link_if.sv
`timescale 1ns/10ps
interface seq_link_if;
    logic       on;
    logic       byte_vld;
    logic [7:0] byte_dat;
    logic       byte_seen;
    logic       byte_bad;
    logic       locked;
    logic       lost;
    modport core (input on, byte_vld, byte_dat,
                  output byte_seen, byte_bad, locked, lost);
    modport host (output on, byte_vld, byte_dat,
                  input byte_seen, byte_bad, locked, lost);
endinterface : seq_link_if

// File: seq_checker_core.sv
`timescale 1ns/10ps
`include "prbs_chk_map.svh"
module seq_checker_core #(
    parameter int unsigned LOCK_GOOD = `SCK_LOCK_GOOD,
    parameter int unsigned LOSS_BAD  = `SCK_LOSS_BAD
) (
    input  wire logic pclk,
    input  wire logic presetn,
    seq_link_if.core  link
);
    import prbs_chk_pkg::*;

    if (LOCK_GOOD < 1 || LOCK_GOOD > 15 || LOSS_BAD < 1 || LOSS_BAD > 15)
    begin : g_bad_counts
        $error("lock counts must be 1 to 15");
    end

    lock_state_type state_q;
    logic [6:0]     seed_q;
    logic [3:0]     good_q;
    logic [3:0]     bad_q;
    logic           seen_q;
    logic           bad_byte_q;
    logic           lost_q;
    logic [7:0]     step;

    // x^7+x^6+1, msb first; self-synchronising on the returned bits so
    // a single bit error costs at most two bytes, not a lost lock
    function automatic logic [7:0] prbs_step(input logic [6:0] s,
                                             input logic [7:0] d);
        logic e;
        logic [6:0] t;
        e = 1'b0;
        t = s;
        for (int i = 7; i >= 0; i--) begin
            e = e | (d[i] ^ t[6] ^ t[5]);
            t = {t[5:0], d[i]};
        end
        return {e, t};
    endfunction : prbs_step

    assign step = prbs_step(seed_q, link.byte_dat);

    // hunt for a clean run, then check until a run of bad bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_HUNT;
            seed_q     <= 7'h00;
            good_q     <= 4'h0;
            bad_q      <= 4'h0;
            seen_q     <= 1'b0;
            bad_byte_q <= 1'b0;
            lost_q     <= 1'b0;
        end else if (!link.on) begin
            state_q    <= ST_HUNT;
            good_q     <= 4'h0;
            bad_q      <= 4'h0;
            seen_q     <= 1'b0;
            bad_byte_q <= 1'b0;
            lost_q     <= 1'b0;
        end else begin
            seen_q     <= 1'b0;
            bad_byte_q <= 1'b0;
            lost_q     <= 1'b0;
            if (link.byte_vld) begin
                seed_q <= step[6:0];
                unique case (state_q)
                    ST_HUNT: begin
                        if (step[7]) begin
                            good_q <= 4'h0;
                        end else if (good_q == 4'(LOCK_GOOD - 1)) begin
                            good_q  <= 4'h0;
                            state_q <= ST_LOCKED;
                        end else begin
                            good_q <= good_q + 4'h1;
                        end
                    end
                    ST_LOCKED: begin
                        seen_q     <= 1'b1;
                        bad_byte_q <= step[7];
                        if (!step[7]) begin
                            bad_q <= 4'h0;
                        end else if (bad_q == 4'(LOSS_BAD - 1)) begin
                            bad_q   <= 4'h0;
                            state_q <= ST_HUNT;
                            lost_q  <= 1'b1;
                        end else begin
                            bad_q <= bad_q + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    assign link.byte_seen = seen_q;
    assign link.byte_bad  = bad_byte_q;
    assign link.locked    = (state_q == ST_LOCKED);
    assign link.lost      = lost_q;

    property p_lost_from_lock;
        @(posedge pclk) disable iff (!presetn)
        link.lost |-> $past(state_q) == ST_LOCKED && state_q == ST_HUNT;
    endproperty
    a_lost_from_lock: assert property (p_lost_from_lock)
        else $error("sync loss without prior lock");
endmodule : seq_checker_core

// File: prbs_tx_byte_checker.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "prbs_chk_map.svh"
// Function
// - checker runs on looped-back bytes only while control bit 0 set.
// - control bit 1 picks continuous (1) or saturating single (0).
// - errored bytes counted in read-only bits 14..7, stop at 0xFF in single mode.
// - writing one to bit 7 freezes a snapshot of the counters.
// - writing one to bit 8 freezes the snapshot and clears counters.
// - sync loss sets bit 5, held high even after sync returns.
// - bit 4 shows live lock status of the checker.
// - overflow bit 2 sets when the total byte count reaches its top.
// - sixteen-bit total byte count, read value frozen by bit 7 or 8.
// - in single mode the total count stops at 0xFFFF.
module prbs_tx_byte_checker #(
    parameter int unsigned LOCK_GOOD = `SCK_LOCK_GOOD,
    parameter int unsigned LOSS_BAD  = `SCK_LOSS_BAD
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire prbs_chk_pkg::bus_addr_type paddr,
    input  wire prbs_chk_pkg::bus_word_type pwdata,
    output      prbs_chk_pkg::bus_word_type prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       rx_byte_valid,
    input  wire logic [7:0]                 rx_byte,
    output logic                            irq
);
    import prbs_chk_pkg::*;

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    logic         on_q;
    logic         cont_q;
    logic [15:0]  total_live_q;
    logic [7:0]   err_live_q;
    logic [15:0]  total_snap_q;
    logic [7:0]   err_snap_q;
    logic         ovf_q;
    logic         sloss_q;
    logic         locked_q;
    logic [2:0]   irq_sts_q;
    logic [2:0]   irq_en_q;
    logic         irq_q;
    bus_word_type prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic [7:0]   idx;
    logic         addr_ok;
    logic         ctrl_hit;
    logic         total_hit;
    logic         sts_hit;
    logic         clr_hit;
    logic         en_hit;
    logic         mapped;
    logic         setup;
    logic         wr_done;
    logic         rd_done;
    logic         ctrl_wr;
    logic         freeze_cmd;
    logic         clear_cmd;
    logic         ovf_set;
    logic         sloss_clr;
    logic [2:0]   irq_evt;
    logic [15:0]  ctrl_word;

    seq_link_if link ();

    seq_checker_core #(
        .LOCK_GOOD (LOCK_GOOD),
        .LOSS_BAD  (LOSS_BAD)
    ) u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (link.core)
    );

    assign link.on       = on_q;
    assign link.byte_vld = rx_byte_valid;
    assign link.byte_dat = rx_byte;

    //--------------------------------------------------------------
    // apb decode
    //--------------------------------------------------------------
    // one wait-free access: pready rises in the access phase only
    assign idx       = paddr[9:2];
    assign addr_ok   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign ctrl_hit  = addr_ok && (idx == `SCK_CTRL_IDX);
    assign total_hit = addr_ok && (idx == `SCK_TOTAL_IDX);
    assign sts_hit   = addr_ok && (idx == `SCK_IRQ_STS_IDX);
    assign clr_hit   = addr_ok && (idx == `SCK_IRQ_CLR_IDX);
    assign en_hit    = addr_ok && (idx == `SCK_IRQ_EN_IDX);
    assign mapped    = ctrl_hit | total_hit | sts_hit | clr_hit | en_hit;
    assign setup     = psel && !penable;
    assign wr_done   = psel && penable && pready_q && pwrite;
    assign rd_done   = psel && penable && pready_q && !pwrite;
    assign ctrl_wr   = wr_done && ctrl_hit;

    // the trigger bits sit under read-only count bits; only a one acts
    assign freeze_cmd = ctrl_wr && pwdata[`SCK_FREEZE_BIT];
    assign clear_cmd  = ctrl_wr && pwdata[`SCK_FRZCLR_BIT];

    // handshake and read data, captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite) begin
                unique case (1'b1)
                    ctrl_hit:  prdata_q <= {16'h0000, ctrl_word};
                    total_hit: prdata_q <= {16'h0000, total_snap_q};
                    sts_hit:   prdata_q <= {29'h0, irq_sts_q};
                    en_hit:    prdata_q <= {29'h0, irq_en_q};
                    default:   prdata_q <= '0; // clear reg, unmapped
                endcase
            end
        end
    end

    assign ctrl_word = {1'b0, err_snap_q, 1'b0, sloss_q,
                        link.locked, 1'b0, ovf_q, cont_q, on_q};

    //--------------------------------------------------------------
    // control register
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q   <= 1'(`SCK_CTRL_RST >> `SCK_ON_BIT);
            cont_q <= 1'b0;
        end else if (ctrl_wr) begin
            on_q   <= pwdata[`SCK_ON_BIT];
            cont_q <= pwdata[`SCK_CONT_BIT];
        end
    end

    //--------------------------------------------------------------
    // live counters
    //--------------------------------------------------------------
    // a byte landing with a clear is dropped; the clear is the epoch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_live_q <= `SCK_TOTAL_RST;
        end else if (clear_cmd) begin
            total_live_q <= 16'h0000;
        end else if (link.byte_seen) begin
            if (total_live_q != 16'hFFFF) begin
                total_live_q <= total_live_q + 16'h0001;
            end else if (cont_q) begin
                total_live_q <= 16'h0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_live_q <= 8'h00;
        end else if (clear_cmd) begin
            err_live_q <= 8'h00;
        end else if (link.byte_seen && link.byte_bad) begin
            if (err_live_q != 8'hFF) begin
                err_live_q <= err_live_q + 8'h01;
            end else if (cont_q) begin
                err_live_q <= 8'h00;
            end
        end
    end

    // software only ever sees the frozen copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_snap_q <= 16'h0000;
            err_snap_q   <= 8'h00;
        end else if (freeze_cmd || clear_cmd) begin
            total_snap_q <= total_live_q;
            err_snap_q   <= err_live_q;
        end
    end

    //--------------------------------------------------------------
    // sticky flags
    //--------------------------------------------------------------
    assign ovf_set   = link.byte_seen && !clear_cmd &&
                       (total_live_q == 16'hFFFE);
    assign sloss_clr = rd_done && ctrl_hit && link.locked;

    // overflow holds until the counters are cleared; a clear in the same cycle blocks the set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (clear_cmd) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sloss_q <= 1'b0;
        end else if (link.lost) begin
            sloss_q <= 1'b1;
        end else if (sloss_clr) begin
            sloss_q <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // interrupts
    //--------------------------------------------------------------
    assign irq_evt = {link.locked && !locked_q, ovf_set, link.lost};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_q  <= 1'b0;
            irq_sts_q <= 3'h0;
            irq_en_q  <= 3'h0;
            irq_q     <= 1'b0;
        end else begin
            locked_q <= link.locked;
            // write-one-to-clear, but a new event in the same cycle stays
            if (wr_done && clr_hit) begin
                irq_sts_q <= (irq_sts_q & ~pwdata[2:0]) | irq_evt;
            end else begin
                irq_sts_q <= irq_sts_q | irq_evt;
            end
            if (wr_done && en_hit) begin
                irq_en_q <= pwdata[2:0];
            end
            irq_q <= |(irq_sts_q & irq_en_q);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_write(int b);
        ctrl_wr && pwdata[b];
    endsequence
    sequence s_at_top;
        link.byte_seen && !clear_cmd && total_live_q == 16'hFFFF;
    endsequence

    property p_gate;
        !$past(on_q) |-> !link.byte_seen;
    endproperty
    a_gate: assert property (p_gate)
        else $error("bytes counted while checker off");

    property p_single_stop;
        s_at_top ##0 !cont_q |=> total_live_q == 16'hFFFF;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("total count left top in single mode");

    property p_wrap;
        s_at_top ##0 cont_q |=> total_live_q == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("total count did not wrap");

    property p_err_stop;
        link.byte_seen && link.byte_bad && !clear_cmd && !cont_q &&
        err_live_q == 8'hFF |=> err_live_q == 8'hFF;
    endproperty
    a_err_stop: assert property (p_err_stop)
        else $error("error count left top in single mode");

    property p_count;
        link.byte_seen && !clear_cmd && total_live_q != 16'hFFFF
        |=> total_live_q == 16'($past(total_live_q) + 16'h0001);
    endproperty
    a_count: assert property (p_count)
        else $error("total count missed a byte");

    property p_freeze;
        s_ctrl_write(`SCK_FREEZE_BIT) |=> total_snap_q ==
            $past(total_live_q) ##1 $stable(total_snap_q) || ctrl_wr;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("snapshot not taken or not held");

    property p_clear;
        s_ctrl_write(`SCK_FRZCLR_BIT) |=> total_live_q == 16'h0000 &&
            err_live_q == 8'h00 && err_snap_q == $past(err_live_q);
    endproperty
    a_clear: assert property (p_clear)
        else $error("freeze and clear failed");

    property p_sloss_hold;
        link.lost ##1 !sloss_clr[*2] |-> sloss_q ##1 sloss_q;
    endproperty
    a_sloss_hold: assert property (p_sloss_hold)
        else $error("sync loss flag not held");

    property p_lock_read;
        setup && !pwrite && ctrl_hit
        |=> prdata_q[`SCK_LOCK_BIT] == $past(link.locked);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit read wrong");

    property p_ovf;
        ovf_set |=> ovf_q && total_live_q == 16'hFFFF;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag missed");

    property p_sloss_clr;
        sloss_clr && !link.lost |=> !sloss_q;
    endproperty
    a_sloss_clr: assert property (p_sloss_clr)
        else $error("sync loss not cleared on read");

    property p_mode;
        ctrl_wr |=> cont_q == $past(pwdata[`SCK_CONT_BIT]);
    endproperty
    a_mode: assert property (p_mode)
        else $error("count mode not written");
endmodule : prbs_tx_byte_checker

// File: prbs_loop_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// far end of the reverse loop: sends x^7+x^6+1 bytes, msb first
// ---------------------------------------------------------------
module prbs_loop_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       flip,
    output logic            rx_byte_valid,
    output logic [7:0]      rx_byte
);
    logic [6:0] gen_q;
    logic [6:0] gen_d;
    logic [7:0] next_byte;

    // next eight sequence bits, first bit in the msb
    always_comb begin
        gen_d = gen_q;
        for (int i = 7; i >= 0; i--) begin
            next_byte[i] = gen_d[6] ^ gen_d[5];
            gen_d        = {gen_d[5:0], next_byte[i]};
        end
    end

    // the generator runs on true bits, so a flipped byte spoils only
    // the wire and the far end stays on the sequence afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q         <= 7'h7F;
            rx_byte_valid <= 1'b0;
            rx_byte       <= 8'h00;
        end else if (go) begin
            gen_q         <= gen_d;
            rx_byte_valid <= 1'b1;
            rx_byte       <= flip ? ~next_byte : next_byte;
        end else begin
            rx_byte_valid <= 1'b0;
            rx_byte       <= ~rx_byte; // no stale byte between strobes
        end
    end
endmodule : prbs_loop_model

// File: prbs_tx_byte_checker_bench.sv
`timescale 1ns/10ps
module prbs_tx_byte_checker_bench;
    import prbs_chk_pkg::*;
    localparam bus_addr_type A_CTRL  = 12'h0E4;
    localparam bus_addr_type A_TOTAL = 12'h0E8;
    localparam bus_addr_type A_STS   = 12'h0EC;
    localparam bus_addr_type A_CLR   = 12'h0F0;
    localparam bus_addr_type A_ENA   = 12'h0F4;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    bus_addr_type paddr;
    bus_word_type pwdata;
    bus_word_type prdata;
    logic         pready;
    logic         pslverr;
    logic         rx_byte_valid;
    logic [7:0]   rx_byte;
    logic         irq;
    logic         go;
    logic         flip;
    bus_word_type rd;
    logic         err;
    int           fails;
    int           n_checks;

    // 25 MHz
    always #20 pclk = ~pclk;

    prbs_tx_byte_checker dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .irq(irq));

    prbs_loop_model loop_u (
        .pclk(pclk), .presetn(presetn), .go(go), .flip(flip),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input bus_word_type exp,
                       input bus_word_type got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s exp %h got %h", what, exp, got);
            fails++;
        end
    endtask : chk

    // one apb transfer; a slave that never answers ends the run
    task automatic apb(input logic wr, input bus_addr_type a,
                       input bus_word_type d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fails++;
            wrap_up();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string what, input bus_addr_type a,
                          input bus_word_type exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    // n back-to-back bytes; byte i flipped when i mod every < run
    task automatic send(input int n, input int every, input int run);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            go   <= 1'b1;
            flip <= (i % every) < run;
        end
        @(posedge pclk);
        go   <= 1'b0;
        flip <= 1'b0;
        repeat (4) @(posedge pclk); // counters land two edges later
    endtask : send

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd_chk("ctrl rst", A_CTRL, 32'h0);
        apb(1'b1, A_TOTAL, 32'h0000_1234);
        rd_chk("total ro", A_TOTAL, 32'h0);
        rd_chk("sts rst", A_STS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h4E4, 32'h0000_0003);
        chk("alias err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h0E5, 32'h0);
        chk("misaligned err", 32'h1, {31'h0, err});
        chk("misaligned data", 32'h0, rd);
        rd_chk("alias ignored", A_CTRL, 32'h0);
        chk("irq rst", 32'h0, {31'h0, irq});
    endtask : t_reset

    task automatic t_off;
        send(12, 1, 0);
        rd_chk("lock when off", A_CTRL, 32'h0);
        rd_chk("sts when off", A_STS, 32'h0);
    endtask : t_off

    // lock event also walks the interrupt: masked, enabled, cleared
    task automatic t_lock;
        apb(1'b1, A_CTRL, 32'h0000_0001);
        send(12, 1, 0);
        rd_chk("locked", A_CTRL, 32'h0000_0011);
        rd_chk("lock sts", A_STS, 32'h0000_0004);
        rd_chk("clr reads 0", A_CLR, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, A_ENA, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, A_CLR, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk("irq clr", 32'h0, {31'h0, irq});
        apb(1'b1, A_ENA, 32'h0);
    endtask : t_lock

    // one flipped byte on the wire counts as two errored bytes; later bytes stay out
    task automatic t_count;
        apb(1'b1, A_CTRL, 32'h0000_0101);
        send(10, 10, 1);
        apb(1'b1, A_CTRL, 32'h0000_0081);
        send(5, 1, 0);
        rd_chk("total", A_TOTAL, 32'h0000_000A);
        rd_chk("errors", A_CTRL, 32'h0000_0111);
    endtask : t_count

    task automatic t_errsat;
        apb(1'b1, A_CTRL, 32'h0000_0101);
        send(520, 4, 1);
        apb(1'b1, A_CTRL, 32'h0000_0081);
        rd_chk("err sat", A_CTRL, 32'h0000_7F91);
    endtask : t_errsat

    task automatic t_errwrap;
        apb(1'b1, A_CTRL, 32'h0000_0103);
        send(520, 4, 1);
        apb(1'b1, A_CTRL, 32'h0000_0083);
        rd_chk("err wrap", A_CTRL, 32'h0000_0213);
    endtask : t_errwrap

    task automatic t_total;
        apb(1'b1, A_CTRL, 32'h0000_0101);
        send(65536, 1, 0);
        apb(1'b1, A_CTRL, 32'h0000_0081);
        rd_chk("total sat", A_TOTAL, 32'h0000_FFFF);
        rd_chk("overflow", A_CTRL, 32'h0000_0015);
        // switch to continuous at the top: the next byte wraps to zero
        apb(1'b1, A_CTRL, 32'h0000_0003);
        send(2, 1, 0);
        apb(1'b1, A_CTRL, 32'h0000_0083);
        rd_chk("total wrap", A_TOTAL, 32'h0000_0001);
    endtask : t_total

    task automatic t_loss;
        apb(1'b1, A_CTRL, 32'h0000_0101);
        apb(1'b1, A_ENA, 32'h0000_0001);
        send(4, 1, 1);
        rd_chk("loss", A_CTRL, 32'h0000_0021);
        chk("irq loss", 32'h1, {31'h0, irq});
        send(12, 1, 0);
        rd_chk("loss held", A_CTRL, 32'h0000_0031);
        rd_chk("loss gone", A_CTRL, 32'h0000_0011);
        apb(1'b1, A_CLR, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask : t_loss

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        pclk     = 1'b0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        go       = 1'b0;
        flip     = 1'b0;
        fails    = 0;
        n_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_off();
        t_lock();
        t_count();
        t_errsat();
        t_errwrap();
        t_total();
        t_loss();
        wrap_up();
    end
endmodule : prbs_tx_byte_checker_bench
